// ### ehl_defines.svh
// register offsets, field positions and limits of the error history log
`ifndef EHL_DEFINES_SVH
`define EHL_DEFINES_SVH

`define EHL_ADDR_ERASE      16'h3b08
`define EHL_ADDR_PTR_RST    16'h3b0a
`define EHL_ADDR_ERR_NUM    16'h3c02
`define EHL_ADDR_ERR_CLASS  16'h3c04
`define EHL_ADDR_ERR_TIME   16'h3c06
`define EHL_ADDR_ERR_QUAL   16'h3c08

`define EHL_CMD_GO          16'h0001
`define EHL_DEPTH           10
`define EHL_TIME_MAX        32'h1fffffff
`define EHL_CLASS_LOCKED    3'h4
`define EHL_NO_ERROR        16'h0000
`define EHL_DRV_ERR_BIT     15
`define EHL_MODE_ERR_BIT    6

`endif

// ### ehl_error_history_log.sv
// error history log with sequential read pointer, error flags and mode rejection
`timescale 1ns/1ps
`default_nettype none
`include "ehl_defines.svh"

module ehl_error_history_log
    import ehl_pkg::*;
#(
    parameter int DEPTH = `EHL_DEPTH
) (
    input  wire logic        i_ref_clk,
    input  wire logic        i_resetn,
    input  wire logic        i_par_rd,
    input  wire logic        i_par_wr,
    input  wire logic [15:0] i_par_addr,
    input  wire logic [15:0] i_par_wdata,
    input  wire logic        i_err_event,
    input  wire logic [15:0] i_err_number,
    input  wire logic [2:0]  i_err_class,
    input  wire logic [15:0] i_err_qual,
    input  wire logic [31:0] i_op_hours_s,
    input  wire logic        i_err_reset_cmd,
    input  wire logic        i_frame_valid,
    input  wire logic        i_mode_req,
    input  wire logic        i_mode_ok,
    input  wire logic [15:0] i_mode_fail_code,
    output logic [31:0]      o_par_rdata,
    output logic             o_par_rvalid,
    output logic [15:0]      o_drive_status_word,
    output logic [15:0]      o_mode_status_word,
    output logic [15:0]      o_mode_reject_code,
    output logic [15:0]      o_last_stop_cause
);

    localparam int PW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] FULL = PW'(DEPTH);

    ////////////////////////////////////////////////////////////////////////
    // reset release

    logic rst_meta_q;
    logic rst_sync_q;
    wire  rst_n = rst_sync_q;

    // two-stage release of the async reset
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // decode helpers

    function automatic logic hit(input logic [15:0] a, input logic [15:0] ref_a);
        hit = (a == ref_a);
    endfunction : hit

    function automatic logic [31:0] cap_time(input logic [31:0] t);
        cap_time = (t > `EHL_TIME_MAX) ? `EHL_TIME_MAX : t;
    endfunction : cap_time

    wire wr_erase  = i_par_wr && hit(i_par_addr, `EHL_ADDR_ERASE) && i_par_wdata == `EHL_CMD_GO;
    wire wr_ptrrst = i_par_wr && hit(i_par_addr, `EHL_ADDR_PTR_RST) && i_par_wdata == `EHL_CMD_GO;
    wire rd_num    = i_par_rd && hit(i_par_addr, `EHL_ADDR_ERR_NUM);

    ////////////////////////////////////////////////////////////////////////
    // active error tracking

    logic        active_q;
    logic [15:0] active_num_q;
    logic [2:0]  active_cls_q;
    logic        indic_q;
    ehl_state_e  state_q;
    wire         erasing = (state_q == EHL_WIPE);

    // triggering error only; follow-ups ignored
    wire take_err = i_err_event && !active_q && !erasing;

    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            active_q     <= 1'b0;
            active_num_q <= `EHL_NO_ERROR;
            active_cls_q <= 3'h0;
        end else if (take_err) begin
            active_q     <= 1'b1;
            active_num_q <= i_err_number;
            active_cls_q <= i_err_class;
        end else if (i_err_reset_cmd && active_cls_q != `EHL_CLASS_LOCKED) begin
            active_q     <= 1'b0;
            active_num_q <= `EHL_NO_ERROR;
            active_cls_q <= 3'h0;
        end
    end

    // error indication: set on error, dropped by next valid frame; set wins
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            indic_q <= 1'b0;
        end else if (take_err) begin
            indic_q <= 1'b1;
        end else if (i_frame_valid) begin
            indic_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // history storage, not reset so it persists

    ehl_entry_s    mem_q [DEPTH];
    logic [PW-1:0] count_q;
    logic [PW-1:0] wipe_idx_q;
    logic [PW-1:0] ptr_q;

    ehl_entry_s new_entry;
    always_comb begin
        new_entry.number    = i_err_number;
        new_entry.err_class = i_err_class;
        new_entry.err_time  = cap_time(i_op_hours_s);
        new_entry.qual      = i_err_qual;
    end

    // append, shifting out the oldest when full
    always_ff @(posedge i_ref_clk) begin
        if (erasing) begin
            mem_q[wipe_idx_q] <= '0;
        end else if (take_err) begin
            if (count_q == FULL) begin
                for (int i = 0; i < DEPTH - 1; i++) begin
                    mem_q[i] <= mem_q[i+1];
                end
                mem_q[DEPTH-1] <= new_entry;
            end else begin
                mem_q[count_q] <= new_entry;
            end
        end
    end

    // fill level, kept across reset
    always_ff @(posedge i_ref_clk) begin
        if (erasing) begin
            count_q <= '0;
        end else if (take_err && count_q != FULL) begin
            count_q <= count_q + PW'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // eraser: one entry per cycle

    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q    <= EHL_IDLE;
            wipe_idx_q <= '0;
        end else begin
            unique case (state_q)
                EHL_IDLE: begin
                    if (wr_erase) begin
                        state_q    <= EHL_WIPE;
                        wipe_idx_q <= '0;
                    end
                end
                EHL_WIPE: begin
                    if (wipe_idx_q == FULL - PW'(1)) begin
                        state_q <= EHL_IDLE;
                    end
                    wipe_idx_q <= wipe_idx_q + PW'(1);
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read pointer and holding buffer

    ehl_entry_s hold_q;

    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ptr_q <= '0;
        end else if (wr_ptrrst || erasing) begin
            ptr_q <= '0;
        end else if (rd_num && ptr_q != FULL) begin
            ptr_q <= ptr_q + PW'(1);
        end
    end

    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_q <= '0;
        end else if (rd_num) begin
            if (ptr_q < count_q) begin
                hold_q <= mem_q[ptr_q];
            end else begin
                hold_q <= '0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // parameter channel read data, one cycle after request

    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_par_rdata  <= '0;
            o_par_rvalid <= 1'b0;
        end else begin
            o_par_rvalid <= i_par_rd;
            o_par_rdata  <= '0;
            if (i_par_rd) begin
                unique case (i_par_addr)
                    `EHL_ADDR_ERASE:     o_par_rdata <= {31'h0, erasing || wr_erase};
                    `EHL_ADDR_ERR_NUM:   o_par_rdata <= (ptr_q < count_q) ? {16'h0, mem_q[ptr_q].number} : '0;
                    `EHL_ADDR_ERR_CLASS: o_par_rdata <= {29'h0, hold_q.err_class};
                    `EHL_ADDR_ERR_TIME:  o_par_rdata <= hold_q.err_time;
                    `EHL_ADDR_ERR_QUAL:  o_par_rdata <= {16'h0, hold_q.qual};
                    default:             o_par_rdata <= '0;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // process data status words and mode rejection

    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_drive_status_word <= '0;
            o_last_stop_cause   <= `EHL_NO_ERROR;
        end else begin
            o_drive_status_word <= '0;
            o_drive_status_word[`EHL_DRV_ERR_BIT] <= indic_q;
            o_last_stop_cause <= active_q ? active_num_q : `EHL_NO_ERROR;
        end
    end

    // rejection only flags; nothing here stops the running operation
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_mode_status_word <= '0;
            o_mode_reject_code <= '0;
        end else if (i_mode_req) begin
            o_mode_status_word[`EHL_MODE_ERR_BIT] <= !i_mode_ok;
            if (!i_mode_ok) begin
                o_mode_reject_code <= i_mode_fail_code;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!rst_n);

    cause_zero_idle_a: assert property (!active_q |=> o_last_stop_cause == 16'h0)
        else $error("stop cause not zero while idle");
    follow_ignored_a: assert property (active_q && i_err_event |=> $stable(count_q) || count_q == FULL)
        else $error("follow-up error recorded");
    indic_clear_a: assert property (indic_q && i_frame_valid && !take_err |=> ##1 !o_drive_status_word[15])
        else $error("error bit not cleared by frame");
    drive_bit_a: assert property (take_err |=> ##1 o_drive_status_word[15])
        else $error("drive error bit missing");
    mode_reject_a: assert property (i_mode_req && !i_mode_ok |=> o_mode_status_word[6]
                                    && o_mode_reject_code == $past(i_mode_fail_code))
        else $error("mode rejection not flagged");
    // index reaching its last value after nine more cycles implies an unbroken wipe
    erase_done_a: assert property (wr_erase && !erasing |=> erasing ##9 (erasing && wipe_idx_q == 4'd9)
                                   ##1 (!erasing && count_q == 0))
        else $error("erase did not finish in ten cycles");
    ptr_reset_a: assert property (wr_ptrrst && !erasing |=> ptr_q == 0)
        else $error("pointer not reset");
    ptr_step_a: assert property (rd_num && !wr_ptrrst && !erasing && ptr_q < 4'd10 |=> ptr_q == $past(ptr_q) + 1)
        else $error("pointer did not advance");
    empty_zero_a: assert property (rd_num && ptr_q >= count_q |=> o_par_rdata == 0)
        else $error("empty position not zero");
    locked_hold_a: assert property (active_q && active_cls_q == 3'h4 && i_err_reset_cmd |=> active_q)
        else $error("class 4 cleared by reset command");
    // fill level is unknown until the first erase, so check it after each append
    full_cap_a: assert property (take_err |=> count_q <= FULL)
        else $error("history overfilled");

    cover_full_c:   cover property (take_err && count_q == FULL);
    cover_walk_c:   cover property (rd_num ##1 rd_num ##1 rd_num);
    cover_erase_c:  cover property (wr_erase ##1 erasing);
    cover_reject_c: cover property (i_mode_req && !i_mode_ok);

endmodule : ehl_error_history_log

`default_nettype wire

// ### ehl_master_model.sv
// fieldbus master model on the parameter channel
`timescale 1ns/1ps
`default_nettype none
`include "ehl_defines.svh"

module ehl_master_model (
    input  wire logic        i_clk,
    input  wire logic [31:0] i_rdata,
    input  wire logic        i_rvalid,
    output var  logic        o_rd,
    output var  logic        o_wr,
    output var  logic [15:0] o_addr,
    output var  logic [15:0] o_wdata
);
    // idle bus at time zero
    initial begin
        o_rd = 1'b0;
        o_wr = 1'b0;
        o_addr = 16'h0000;
        o_wdata = 16'h0000;
    end

    // one write strobe, released bus shows inverted values
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge i_clk);
        o_wr <= 1'b1;
        o_addr <= a;
        o_wdata <= d;
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_addr <= ~a;
        o_wdata <= ~d;
    endtask : wr

    // one read strobe, answer taken when valid, bounded wait
    task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic ok);
        ok = 1'b0;
        d = 32'h0;
        @(posedge i_clk);
        o_rd <= 1'b1;
        o_addr <= a;
        for (int i = 0; i < 4 && !ok; i++) begin
            @(posedge i_clk);
            o_rd <= 1'b0;
            o_addr <= ~a;
            #1;
            if (i_rvalid === 1'b1) begin
                d = i_rdata;
                ok = 1'b1;
            end
        end
    endtask : rd

    // erase, then poll until it reads zero
    task automatic erase(output logic [31:0] first, output logic ok);
        logic [31:0] d;
        logic        got;
        ok = 1'b0;
        wr(`EHL_ADDR_ERASE, `EHL_CMD_GO);
        rd(`EHL_ADDR_ERASE, first, got);
        for (int i = 0; i < 20 && got && !ok; i++) begin
            rd(`EHL_ADDR_ERASE, d, got);
            ok = (d === 32'h0);
        end
    endtask : erase

    // number first, then the fields from the holding buffer
    task automatic read_entry(output logic [31:0] n, c, t, q, output logic ok);
        logic g1, g2, g3;
        rd(`EHL_ADDR_ERR_NUM, n, ok);
        rd(`EHL_ADDR_ERR_CLASS, c, g1);
        rd(`EHL_ADDR_ERR_TIME, t, g2);
        rd(`EHL_ADDR_ERR_QUAL, q, g3);
        ok = ok & g1 & g2 & g3;
    endtask : read_entry

    // pointer back to the oldest entry before a walk
    task automatic rewind();
        wr(`EHL_ADDR_PTR_RST, `EHL_CMD_GO);
    endtask : rewind
endmodule : ehl_master_model
`default_nettype wire

// ### ehl_pkg.sv
// types shared by the error history log
package ehl_pkg;

    // warning, two quick-stop classes, fatal, fatal locked
    typedef enum logic [2:0] {
        EHL_CLS_WARN,
        EHL_CLS_QSTOP7,
        EHL_CLS_QSTOP89,
        EHL_CLS_FATAL,
        EHL_CLS_FATAL_LOCKED
    } ehl_class_e;

    // one history entry
    typedef struct packed {
        logic [15:0] number;
        logic [2:0]  err_class;
        logic [31:0] err_time;
        logic [15:0] qual;
    } ehl_entry_s;

    // eraser state
    typedef enum logic {
        EHL_IDLE,
        EHL_WIPE
    } ehl_state_e;

endpackage : ehl_pkg

// ### tb_error_history_log.sv
// self-checking bench of the error history log
`timescale 1ns/1ps
`default_nettype none
`include "ehl_defines.svh"

module tb_error_history_log;
    logic        clk, resetn, err_ev, rst_cmd, frame, mode_req, mode_ok, par_rd, par_wr, rvalid, ok;
    logic [2:0]  err_cls;
    logic [15:0] err_num, err_qual, mode_code, par_addr, par_wdata, drv_sw, mode_sw, rej_code, stop_cause;
    logic [31:0] hours, rdata, n, c, t, q;
    int          mismatches;
    int          total_checks;

    ehl_error_history_log uut (.i_ref_clk(clk), .i_resetn(resetn), .i_par_rd(par_rd), .i_par_wr(par_wr),
        .i_par_addr(par_addr), .i_par_wdata(par_wdata), .i_err_event(err_ev), .i_err_number(err_num),
        .i_err_class(err_cls), .i_err_qual(err_qual), .i_op_hours_s(hours), .i_err_reset_cmd(rst_cmd),
        .i_frame_valid(frame), .i_mode_req(mode_req), .i_mode_ok(mode_ok), .i_mode_fail_code(mode_code),
        .o_par_rdata(rdata), .o_par_rvalid(rvalid), .o_drive_status_word(drv_sw),
        .o_mode_status_word(mode_sw), .o_mode_reject_code(rej_code), .o_last_stop_cause(stop_cause));
    ehl_master_model mst (.i_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_rd(par_rd), .o_wr(par_wr),
        .o_addr(par_addr), .o_wdata(par_wdata));

    ////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : summarize

    // a read that never answered ends the run
    task automatic hang(input logic good);
        if (good !== 1'b1) begin
            mismatches++;
            summarize();
        end
    endtask : hang

    task automatic do_reset();
        @(posedge clk);
        resetn <= 1'b0;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
    endtask : do_reset

    // error pulse, settled two cycles after it is taken
    task automatic raise(input logic [15:0] nu, input logic [2:0] cl, input logic [15:0] ql, input logic [31:0] hr);
        @(posedge clk);
        err_ev <= 1'b1;
        err_num <= nu;
        err_cls <= cl;
        err_qual <= ql;
        hours <= hr;
        @(posedge clk);
        err_ev <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask : raise

    task automatic pulse(input logic rc, input logic fv);
        @(posedge clk);
        rst_cmd <= rc;
        frame <= fv;
        @(posedge clk);
        rst_cmd <= 1'b0;
        frame <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask : pulse

    task automatic mode(input logic ok_in, input logic [15:0] cd);
        @(posedge clk);
        mode_req <= 1'b1;
        mode_ok <= ok_in;
        mode_code <= cd;
        @(posedge clk);
        mode_req <= 1'b0;
        @(posedge clk);
        #1;
    endtask : mode

    task automatic entry(input string nm, input logic [15:0] en, input logic [2:0] ec, input logic [31:0] et,
                         input logic [15:0] eq);
        mst.read_entry(n, c, t, q, ok);
        hang(ok);
        chk(nm, {16'h0, en}, n);
        chk("class", {29'h0, ec}, c);
        chk("time", et, t);
        chk("qual", {16'h0, eq}, q);
    endtask : entry

    ////////////////////////////////////////////////////////////////
    // wipe: busy then zero, first entry empty, unmapped read zero
    task automatic s_erase();
        logic [31:0] first;
        mst.erase(first, ok);
        hang(ok);
        chk("erase busy", 32'h1, first);
        mst.rewind();
        entry("empty", 16'h0, 3'h0, 32'h0, 16'h0);
        mst.rd(16'h3c0a, n, ok);
        hang(ok);
        chk("unmapped", 32'h0, n);
    endtask : s_erase

    // one error, a follow-up ignored, frame then reset command clear
    task automatic s_error();
        raise(16'h1234, 3'h1, 16'h00aa, 32'hffffffff);
        chk("stop cause", 32'h1234, {16'h0, stop_cause});
        chk("drive word", 32'h8000, {16'h0, drv_sw});
        raise(16'h5555, 3'h2, 16'h0001, 32'h0);
        chk("stop cause", 32'h1234, {16'h0, stop_cause});
        pulse(1'b0, 1'b1);
        chk("drive word", 32'h0, {16'h0, drv_sw});
        pulse(1'b1, 1'b0);
        chk("stop cause", 32'h0, {16'h0, stop_cause});
        mst.rewind();
        entry("first", 16'h1234, 3'h1, `EHL_TIME_MAX, 16'h00aa);
        entry("follow-up", 16'h0, 3'h0, 32'h0, 16'h0);
    endtask : s_error

    // ten more errors drop the oldest; walk oldest to newest, then empty
    task automatic s_fill();
        for (int i = 1; i <= 10; i++) begin
            raise(16'h0100 + 16'(i), 3'(i % 4), 16'(i), 32'(i * 100));
            pulse(1'b1, 1'b1);
        end
        mst.rewind();
        for (int i = 1; i <= 10; i++) begin
            entry("walk", 16'h0100 + 16'(i), 3'(i % 4), 32'(i * 100), 16'(i));
        end
        entry("past end", 16'h0, 3'h0, 32'h0, 16'h0);
    endtask : s_fill

    // locked error, mode rejected meanwhile, then power cycle
    task automatic s_lock();
        raise(16'h0444, 3'h4, 16'h0000, 32'h5);
        pulse(1'b1, 1'b0);
        chk("locked cause", 32'h0444, {16'h0, stop_cause});
        mode(1'b0, 16'h0bad);
        chk("mode word", 32'h0040, {16'h0, mode_sw});
        chk("reject code", 32'h0bad, {16'h0, rej_code});
        chk("drive word", 32'h8000, {16'h0, drv_sw});
        chk("cause kept", 32'h0444, {16'h0, stop_cause});
        mode(1'b1, 16'h0000);
        chk("mode word", 32'h0, {16'h0, mode_sw});
        chk("reject code", 32'h0bad, {16'h0, rej_code});
        do_reset();
        chk("cause after power", 32'h0, {16'h0, stop_cause});
        mst.rewind();
        entry("kept", 16'h0102, 3'h2, 32'd200, 16'h0002);
    endtask : s_lock

    ////////////////////////////////////////////////////////////////
    // free-running clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // main sequence
    initial begin
        resetn = 1'b0;
        {err_ev, rst_cmd, frame, mode_req, mode_ok} = 5'h00;
        {err_cls, err_num, err_qual, hours, mode_code} = 83'h0;
        mismatches = 0;
        total_checks = 0;
        do_reset();
        s_erase();
        s_error();
        s_fill();
        s_lock();
        summarize();
    end
endmodule : tb_error_history_log
`default_nettype wire
